// *** verilog/mrs_pkg.sv ***
// Constants and types for the keyswitch memory reset sequencer
package mrs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_KHZ       = 10_000;
    localparam int TICK_MS         = 250;
    localparam int TICK_CYCLES_DEF = TICK_MS * CLOCK_KHZ;
    localparam int DIV_W           = 22;
    localparam int ONE_SEC_MS      = 1000;
    localparam int ONE_SEC_TICKS   = ONE_SEC_MS / TICK_MS;
    localparam int RESET_BLINK_S   = 3;
    localparam int RESET_TICKS     = RESET_BLINK_S * ONE_SEC_TICKS;
    localparam int ARM_WINDOW_S    = 3;
    localparam int ARM_TICKS       = ARM_WINDOW_S * ONE_SEC_TICKS;
    localparam int FAST_HALF_MS    = 250;
    localparam int FAST_HALF_TICKS = FAST_HALF_MS / TICK_MS;
    localparam int SLOW_HALF_MS    = 1000;
    localparam int SLOW_HALF_TICKS = SLOW_HALF_MS / TICK_MS;
    localparam int TCNT_W          = 5;

    // ------------------------------------------------------------
    // Keyswitch codes
    // ------------------------------------------------------------
    localparam logic [1:0] KEY_STOP  = 2'h0;
    localparam logic [1:0] KEY_RUN   = 2'h1;
    localparam logic [1:0] KEY_RUN_P = 2'h2;
    localparam logic [1:0] KEY_WIPE  = 2'h3;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] REG_CTRL       = 5'h00;
    localparam logic [4:0] REG_STATUS     = 5'h04;
    localparam logic [4:0] REG_IRQ_STATUS = 5'h08;
    localparam logic [4:0] REG_IRQ_MASK   = 5'h0C;
    localparam logic [4:0] REG_NODE       = 5'h10;
    localparam logic [4:0] REG_UTIL       = 5'h14;

    localparam int CTRL_REQ_BIT  = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam int NODE_ADDR_LSB = 0;
    localparam int NODE_HIGH_LSB = 8;
    localparam int ST_REQ_BIT    = 4;
    localparam int ST_CARD_BIT   = 5;
    localparam int ST_OFFL_BIT   = 6;
    localparam int ST_KEY_LSB    = 8;

    localparam int IRQ_RESET_DONE = 0;
    localparam int IRQ_RESTART    = 1;
    localparam int IRQ_REQUEST    = 2;
    localparam int IRQ_ABANDON    = 3;
    localparam int IRQ_W          = 4;

    localparam logic [1:0]       HOLD_RST     = 2'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
    localparam logic [6:0]       NODE_ADDR_RST = 7'h02;
    localparam logic [6:0]       NODE_HIGH_RST = 7'h0F;
    localparam logic [7:0]       UTIL_RST     = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {LED_OFF, LED_ON, LED_FAST, LED_SLOW} mrs_led_t;

    typedef enum logic [2:0] {
        MODE_STOP, MODE_STARTUP, MODE_RUN, MODE_RUN_P, MODE_HOLD, MODE_MRESET
    } mrs_mode_t;

endpackage

// *** verilog/mrs_sync.sv ***
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module mrs_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule
`default_nettype wire

// *** verilog/mrs_blink.sv ***
// Quarter-second tick divider and stop indicator pattern generator
`timescale 1ns/100ps
`default_nettype none
module mrs_blink
    import mrs_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic     clock,
    input  wire logic     reset_n,
    input  wire mrs_led_t led_mode,
    output logic          tick,
    output logic          led
);
    logic [DIV_W-1:0]  div;
    logic [TCNT_W-1:0] half;
    mrs_led_t          mode_q;
    logic [TCNT_W-1:0] half_len;

    // Phase restarts whenever the pattern changes, but the tick divider runs on, so the
    // first half period of a blink can be up to one tick short.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div  <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (div == DIV_W'(TICK_CYCLES - 1));
            div  <= (div == DIV_W'(TICK_CYCLES - 1)) ? '0 : div + 1'b1;
        end
    end

    assign half_len = (led_mode == LED_SLOW) ? TCNT_W'(SLOW_HALF_TICKS)
                                             : TCNT_W'(FAST_HALF_TICKS);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= LED_OFF;
            half   <= '0;
            led    <= 1'b0;
        end else begin
            mode_q <= led_mode;
            if (led_mode != mode_q) begin
                half <= '0;
                led  <= (led_mode != LED_OFF);
            end else if (led_mode == LED_ON) begin
                led <= 1'b1;
            end else if (led_mode == LED_OFF) begin
                led <= 1'b0;
            end else if (tick) begin
                if (half == half_len - 1'b1) begin
                    half <= '0;
                    led  <= ~led;
                end else begin
                    half <= half + 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/mrs_sequencer.sv ***
// Keyswitch operating mode and memory reset sequencer with Avalon-MM registers
//
// Overview of operation
// (R1) Power-up lights reset indicator, blinks stop 2 Hz for 3 s resetting, then steady.
// (R2) A pending reset request shows as 0.5 Hz stop blinking until reset.
// (R3) Key at stop with no request: stop mode, indicator steadily on.
// (R4) Stop to reset position held: off 1 s, on 1 s, off 1 s, then on.
// (R5) Then stop, reset position again within 3 s, stop: memory reset.
// (R6) Keyswitch memory reset blinks stop 2 Hz at least 3 s, then steady.
// (R7) With request pending, one move to reset position and back starts reset.
// (R8) Reset erases program, clears data except time, self-tests, loads defaults.
// (R9) No card: utilization 0; card present: copy card program and parameters.
// (R10) Diagnostic buffer, time of day and hours counter survive a reset.
// (R11) Port addresses come from card if inserted, else kept.
// (R12) Key straight from stop to a run position: cold restart.
// (R13) After held pattern, moving to run gives warm restart instead.
// (R14) Card inserted or removed while powered raises a reset request.
// (R15) Card changed while unpowered: automatic memory reset at power-up.
// (R16) Programming-device traffic allowed in run_p, run, stop, startup, hold.
// (R17) Missing second move within 3 s abandons sequence, memory kept.
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module mrs_sequencer
    import mrs_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Avalon-MM slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             irq,
    // Pins
    input  wire logic [1:0]  key_pos,
    input  wire logic        card_present,
    input  wire logic        card_changed_offline,
    // Card contents, same clock domain
    input  wire logic [6:0]  card_node_address,
    input  wire logic [6:0]  card_node_highest,
    input  wire logic [7:0]  card_util,
    // Indicators and actions
    output logic             stop_led,
    output logic             reset_indicator,
    output logic             comm_enable,
    output logic             cold_restart,
    output logic             warm_restart,
    output logic             mem_erase,
    output logic             mem_clear,
    output logic             hw_self_test,
    output logic             load_defaults,
    output logic             card_copy,
    output logic [6:0]       node_address,
    output logic [6:0]       node_highest
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [2:0] pins_s;
    logic [1:0] key;
    logic       card_s;
    logic       card_q;
    logic       offline_s;

    // Key codes are not gray-adjacent: KEY_STOP and KEY_WIPE differ in both bits, and a one-cycle glitch
    // between positions is acted on at once, as the state machine has no dwell.
    mrs_sync #(.W(3)) u_sync (
        .clock   (clock),
        .reset_n (reset_n),
        .din     ({card_present, key_pos}),
        .dout    (pins_s)
    );
    mrs_sync #(.W(1)) u_sync_offl (
        .clock   (clock),
        .reset_n (reset_n),
        .din     (card_changed_offline),
        .dout    (offline_s)
    );
    assign key    = pins_s[1:0];
    assign card_s = pins_s[2];

    // ------------------------------------------------------------
    // Sequencer state machine
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_PWRUP, ST_STOP, ST_PATTERN, ST_HELD, ST_ARMED, ST_SECOND,
        ST_REQ_WIPE, ST_MRESET, ST_STARTUP, ST_RUN, ST_HOLD
    } mrs_state_t;

    mrs_state_t        state;
    mrs_state_t        next_state;
    logic [TCNT_W-1:0] ticks;
    logic              tick;
    logic              warm_sel;
    logic              next_warm;
    logic              req_pending;
    logic              offline_seen;
    logic              hold_ctl;
    logic              abandon;
    logic              reset_done;
    logic              entering;
    mrs_led_t          led_mode;
    mrs_mode_t         mode;
    logic              key_run;

    assign key_run  = (key == KEY_RUN) || (key == KEY_RUN_P);
    assign entering = (next_state != state);

    always_comb begin
        next_state = state;
        next_warm  = warm_sel;
        abandon    = 1'b0;
        reset_done = 1'b0;
        unique case (state)
            ST_PWRUP: begin
                if (ticks >= TCNT_W'(RESET_TICKS)) begin // R1 R15
                    next_state = ST_STOP;
                    reset_done = 1'b1;
                end
            end
            ST_STOP: begin
                if (key == KEY_WIPE) begin
                    next_state = req_pending ? ST_REQ_WIPE : ST_PATTERN; // R7
                end else if (key_run && !req_pending) begin
                    next_state = ST_STARTUP; // R12
                    next_warm  = 1'b0;
                end
            end
            ST_PATTERN: begin
                if (key != KEY_WIPE) begin
                    next_state = ST_STOP;
                end else if (ticks >= TCNT_W'(3 * ONE_SEC_TICKS)) begin
                    next_state = ST_HELD; // R4
                end
            end
            ST_HELD: begin
                if (key == KEY_STOP) begin
                    next_state = ST_ARMED;
                end else if (key_run) begin
                    next_state = ST_STARTUP; // R13
                    next_warm  = 1'b1;
                end
            end
            ST_ARMED: begin
                if (key == KEY_WIPE) begin
                    next_state = ST_SECOND; // R5
                end else if (key_run) begin
                    next_state = ST_STARTUP;
                    next_warm  = 1'b0;
                end else if (ticks >= TCNT_W'(ARM_TICKS)) begin
                    next_state = ST_STOP; // R17
                    abandon    = 1'b1;
                end
            end
            ST_SECOND: begin
                if (key == KEY_STOP) begin
                    next_state = ST_MRESET; // R5
                end
            end
            ST_REQ_WIPE: begin
                if (key == KEY_STOP) begin
                    next_state = ST_MRESET; // R7
                end
            end
            ST_MRESET: begin
                // Tick phase is arbitrary on entry, one extra tick keeps the minimum
                if (ticks > TCNT_W'(RESET_TICKS)) begin // R6
                    next_state = ST_STOP;
                    reset_done = 1'b1;
                end
            end
            ST_STARTUP: begin
                next_state = ST_RUN;
            end
            ST_RUN: begin
                if (!key_run) begin
                    next_state = ST_STOP;
                end else if (hold_ctl) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!key_run) begin
                    next_state = ST_STOP;
                end else if (!hold_ctl) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_STOP;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state    <= ST_PWRUP;
            warm_sel <= 1'b0;
        end else begin
            state    <= next_state;
            warm_sel <= next_warm;
        end
    end

    // Time in state, counted in quarter seconds
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ticks <= '0;
        end else if (entering) begin
            ticks <= '0;
        end else if (tick && ticks != '1) begin
            ticks <= ticks + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Indicators
    // ------------------------------------------------------------
    always_comb begin
        led_mode = LED_ON; // R3
        unique case (state)
            ST_PWRUP, ST_MRESET: led_mode = LED_FAST; // R1 R6
            ST_STOP:             led_mode = req_pending ? LED_SLOW : LED_ON; // R2 R3
            ST_REQ_WIPE:         led_mode = LED_SLOW; // R2
            ST_PATTERN: begin
                if (ticks < TCNT_W'(ONE_SEC_TICKS) || ticks >= TCNT_W'(2 * ONE_SEC_TICKS)) begin
                    led_mode = LED_OFF; // R4
                end
            end
            ST_STARTUP, ST_RUN, ST_HOLD: led_mode = LED_OFF;
            default:             led_mode = LED_ON;
        endcase
    end

    mrs_blink #(.TICK_CYCLES(TICK_CYCLES)) u_blink (
        .clock    (clock),
        .reset_n  (reset_n),
        .led_mode (led_mode),
        .tick     (tick),
        .led      (stop_led)
    );

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reset_indicator <= 1'b1;
        end else begin
            reset_indicator <= (next_state == ST_PWRUP); // R1
        end
    end

    // ------------------------------------------------------------
    // Operating mode and programming-device access
    // ------------------------------------------------------------
    always_comb begin
        unique case (state)
            ST_STARTUP: mode = MODE_STARTUP;
            ST_RUN:     mode = (key == KEY_RUN_P) ? MODE_RUN_P : MODE_RUN;
            ST_HOLD:    mode = MODE_HOLD;
            ST_PWRUP, ST_MRESET: mode = MODE_MRESET;
            default:    mode = MODE_STOP;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            comm_enable <= 1'b0;
        end else begin
            comm_enable <= (mode != MODE_MRESET); // R16
        end
    end

    // ------------------------------------------------------------
    // Memory reset actions and restarts
    // ------------------------------------------------------------
    logic        start_reset;
    logic        erase_armed;
    logic [7:0]  util;

    assign start_reset = entering && (next_state == ST_MRESET);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mem_erase     <= 1'b0;
            erase_armed   <= 1'b1;
            mem_clear     <= 1'b0;
            hw_self_test  <= 1'b0;
            load_defaults <= 1'b0;
            card_copy     <= 1'b0;
            cold_restart  <= 1'b0;
            warm_restart  <= 1'b0;
        end else begin
            // Power-up reset is started by the first cycle out of reset
            erase_armed   <= 1'b0;
            mem_erase     <= start_reset || erase_armed; // R8 R15
            // Time of day, diagnostic buffer and hours counter are not in scope
            mem_clear     <= start_reset; // R8 R10
            hw_self_test  <= reset_done; // R8
            load_defaults <= reset_done; // R8
            card_copy     <= reset_done && card_s; // R9
            cold_restart  <= entering && next_state == ST_STARTUP && !next_warm; // R12
            warm_restart  <= entering && next_state == ST_STARTUP && next_warm; // R13
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            util         <= UTIL_RST;
            node_address <= NODE_ADDR_RST;
            node_highest <= NODE_HIGH_RST;
        end else if (reset_done) begin
            util <= card_s ? card_util : UTIL_RST; // R9
            if (card_s) begin
                node_address <= card_node_address; // R11
                node_highest <= card_node_highest; // R11
            end
        end else if (write && !waitrequest && address == REG_NODE) begin
            node_address <= writedata[NODE_ADDR_LSB +: 7];
            node_highest <= writedata[NODE_HIGH_LSB +: 7];
        end
    end

    // ------------------------------------------------------------
    // Reset request tracking
    // ------------------------------------------------------------
    logic card_event;
    logic sw_req;

    assign card_event = (card_s != card_q);
    assign sw_req = write && !waitrequest && address == REG_CTRL && writedata[CTRL_REQ_BIT];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            card_q <= 1'b0;
        end else if (state == ST_PWRUP && ticks == '0) begin
            card_q <= card_s;
        end else begin
            card_q <= card_s;
        end
    end

    // A card change in the ST_MRESET completion cycle keeps the request
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            req_pending <= 1'b0;
        end else if ((card_event && state != ST_PWRUP) || sw_req) begin
            req_pending <= 1'b1; // R14
        end else if (reset_done) begin
            req_pending <= 1'b0; // R2
        end
    end

    // Offline card change strap, caught after reset release
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            offline_seen <= 1'b0;
        end else if (state == ST_PWRUP && offline_s) begin
            offline_seen <= 1'b1; // R15
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave, one wait state per access
    // ------------------------------------------------------------
    logic             ack;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_reported;
    logic [IRQ_W-1:0] irq_event;
    logic [31:0]      rd_mux;

    assign waitrequest = (read || write) && !ack;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (read || write) && !ack;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (address)
            REG_CTRL:       rd_mux[CTRL_HOLD_BIT] = hold_ctl;
            REG_STATUS: begin
                rd_mux[2:0]             = 3'(mode);
                rd_mux[ST_REQ_BIT]      = req_pending;
                rd_mux[ST_CARD_BIT]     = card_s;
                rd_mux[ST_OFFL_BIT]     = offline_seen;
                rd_mux[ST_KEY_LSB +: 2] = key;
            end
            REG_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status;
            REG_IRQ_MASK:   rd_mux[IRQ_W-1:0] = irq_mask;
            REG_NODE: begin
                rd_mux[NODE_ADDR_LSB +: 7] = node_address;
                rd_mux[NODE_HIGH_LSB +: 7] = node_highest;
            end
            REG_UTIL:       rd_mux[7:0] = util;
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readdata     <= 32'h0000_0000;
            irq_reported <= '0;
        end else if (read && !ack) begin
            readdata     <= rd_mux;
            irq_reported <= (address == REG_IRQ_STATUS) ? irq_status : '0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hold_ctl <= HOLD_RST[0];
            irq_mask <= IRQ_MASK_RST;
        end else if (write && ack) begin
            if (address == REG_CTRL) begin
                hold_ctl <= writedata[CTRL_HOLD_BIT];
            end
            if (address == REG_IRQ_MASK) begin
                irq_mask <= writedata[IRQ_W-1:0];
            end
        end
    end

    assign irq_event[IRQ_RESET_DONE] = reset_done;
    assign irq_event[IRQ_RESTART]    = entering && next_state == ST_STARTUP;
    assign irq_event[IRQ_REQUEST]    = card_event && state != ST_PWRUP;
    assign irq_event[IRQ_ABANDON]    = abandon;

    // Only bits shown to the reader are cleared; new events always win
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= '0;
        end else begin
            if (read && ack && address == REG_IRQ_STATUS) begin
                irq_status <= (irq_status & ~irq_reported) | irq_event;
            end else begin
                irq_status <= irq_status | irq_event;
            end
        end
    end

    assign irq = |(irq_status & irq_mask);
endmodule
`default_nettype wire

// *** dv/mrs_sequencer_assertions.sv ***
// Port checker for the memory reset sequencer
`timescale 1ns/100ps
`default_nettype none
module mrs_sequencer_assertions (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic read,
    input  wire logic waitrequest,
    input  wire logic reset_indicator,
    input  wire logic comm_enable,
    input  wire logic cold_restart,
    input  wire logic warm_restart,
    input  wire logic mem_erase,
    input  wire logic mem_clear,
    input  wire logic hw_self_test,
    input  wire logic load_defaults,
    input  wire logic card_copy
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    sequence s_one_wait;
        waitrequest ##1 !waitrequest;
    endsequence
    a_one_wait: assert property ($rose(read) |-> s_one_wait) else $error("read wait");
    a_ind_comm: assert property (reset_indicator |-> !comm_enable) else $error("comm");
    a_cold_pulse: assert property (cold_restart |=> !cold_restart) else $error("cold");
    a_warm_pulse: assert property (warm_restart |=> !warm_restart) else $error("warm");
    a_restart_excl: assert property (!(cold_restart && warm_restart)) else $error("both");
    a_clear_comm: assert property (mem_clear |=> !comm_enable) else $error("clear");
    a_copy_test: assert property (card_copy |-> hw_self_test) else $error("copy");
    a_test_dflt: assert property (hw_self_test |-> load_defaults) else $error("dflt");
    a_erase_once: assert property (mem_erase |=> !mem_erase) else $error("erase");
endmodule
bind mrs_sequencer mrs_sequencer_assertions chk (.*);
`default_nettype wire

// *** dv/mrs_key_model.sv ***
// Model of the operator keyswitch and the load memory card slot
`timescale 1ns/100ps
`default_nettype none
module mrs_key_model (
    input  wire logic       clock,
    input  wire logic [1:0] key_cmd,
    input  wire logic       card_cmd,
    output logic      [1:0] key_pos,
    output logic            card_present,
    output logic      [6:0] card_node_address,
    output logic      [6:0] card_node_highest,
    output logic      [7:0] card_util
);
    initial {key_pos, card_present, card_node_address, card_node_highest, card_util} = '0;
    // An empty slot shows its last contents inverted every cycle, so a steady sampled value must come from a card
    always @(posedge clock) begin
        {key_pos, card_present} <= {key_cmd, card_cmd};
        card_node_address <= card_cmd ? 7'h05 : ~card_node_address;
        card_node_highest <= card_cmd ? 7'h1F : ~card_node_highest;
        card_util        <= card_cmd ? 8'h2A : ~card_util;
    end
endmodule
`default_nettype wire

// *** dv/keyswitch_memory_reset_sequencer_tb.sv ***
// Self-checking bench for the keyswitch memory reset sequencer
`timescale 1ns/100ps
`default_nettype none
module keyswitch_memory_reset_sequencer_tb import mrs_pkg::*; ;
    localparam int S = 4 * ONE_SEC_TICKS;
    logic        clock = 0, reset_n = 0, read = 0, write = 0, card_cmd = 0, irq, stop_led;
    logic        waitrequest, reset_indicator, comm_enable, cold_restart, warm_restart;
    logic        mem_erase, mem_clear, hw_self_test, load_defaults, card_copy, card_present;
    logic [1:0]  key_cmd = KEY_STOP, key_pos;
    logic [4:0]  address = '0;
    logic        offline = 1;
    logic [6:0]  card_node_address, card_node_highest, node_address, node_highest;
    logic [7:0]  card_util;
    logic [3:0]  seen = '0;
    logic [31:0] writedata = '0, readdata, rnd, exp_q[$];
    int          fail_count = 0, tests_run = 0, seed = 55, i;
    always #50 clock = ~clock;
    // Short tick keeps a second at sixteen cycles
    mrs_sequencer #(.TICK_CYCLES(4)) uut (.card_changed_offline(offline), .*);
    mrs_key_model part (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        {address, writedata, write, read} <= {a, d, w, !w};
        if (!w) exp_q.push_back(d);
        do @(posedge clock); while (waitrequest !== 1'b0);
        {write, read} <= 2'b00;
    endtask
    task automatic key(input logic [1:0] k, input int n);
        key_cmd <= k;
        repeat (n) @(posedge clock);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Pulses are gathered as sticky flags, so the sequence checks them at leisure
    always @(posedge clock) begin
        seen <= seen | {warm_restart, cold_restart, mem_clear, card_copy};
        if (read && waitrequest === 1'b0) chk(readdata, exp_q.pop_front());
    end
    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        end_sim;
    end
    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1;
        chk(32'(reset_indicator), 1);
        bus(0, REG_NODE, 32'h0000_0F02);
        bus(0, REG_UTIL, 0);
        repeat (4 * S) @(posedge clock);
        chk(32'({stop_led, reset_indicator, comm_enable}), 32'h0000_0005);
        rnd = $random(seed);
        bus(1, REG_NODE, rnd);
        bus(0, REG_NODE, rnd & 32'h0000_7F7F);
        bus(0, 5'h1C, 0);
        key(KEY_RUN, 8);
        chk(32'(seen), 32'h0000_0004);
        key(KEY_STOP, 8);
        key(KEY_WIPE, 10);
        for (i = 0; i < 4; i++) begin
            chk(32'(stop_led), 32'(i % 2));
            repeat (S) @(posedge clock);
        end
        key(KEY_RUN_P, 8);
        chk(32'(seen), 32'h0000_000C);
        key(KEY_STOP, 8);
        key(KEY_WIPE, 4 * S);
        key(KEY_STOP, 8);
        key(KEY_WIPE, 8);
        key(KEY_STOP, 4 * S);
        chk(32'(seen), 32'h0000_000E);
        bus(0, REG_IRQ_STATUS, 32'h0000_0003);
        key(KEY_WIPE, 4 * S);
        key(KEY_STOP, 5 * S);
        bus(0, REG_IRQ_STATUS, 32'h0000_0008);
        bus(1, REG_IRQ_MASK, 1);
        card_cmd <= 1;
        key(KEY_STOP, 8);
        bus(0, REG_STATUS, 32'h0000_0070);
        key(KEY_WIPE, 8);
        chk(32'(irq), 0);
        key(KEY_STOP, 4 * S);
        chk(32'({irq, seen}), 32'h0000_001F);
        bus(0, REG_NODE, 32'h0000_1F05);
        bus(0, REG_UTIL, 32'h0000_002A);
        bus(0, REG_IRQ_STATUS, 32'h0000_0005);
        @(posedge clock);
        chk(32'(irq), 0);
        end_sim;
    end
endmodule
`default_nettype wire
